// file: hdl/mem_cmd_pkg.sv
// Shared constants for both ends.
// Assumes one clock and sync reset.
package mem_cmd_pkg;
  // ==========================================================================
  // Command and response codes
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_READ = 8'h04;
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_VERIFY_BOOT = 8'h06;
  localparam logic [7:0] RSP_WRITE = 8'h82;
  localparam logic [7:0] RSP_ERASE_WRITE = 8'h83;
  localparam logic [7:0] RSP_READ = 8'h84;
  localparam logic [7:0] RSP_VERIFY = 8'h85;
  localparam logic [7:0] RSP_VERIFY_BOOT = 8'h86;
  // ==========================================================================
  // Field positions and values
  localparam int FAIL_BIT = 0;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_FAIL = 8'h01;
  localparam logic [7:0] OPT_NONE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] IMAGE_MARK = 8'hA5;
  // ==========================================================================
  // Geometry defaults
  localparam int BLOCK_BYTES = 64;
  localparam int NUM_BLOCKS = 4;
  localparam int MAX_PAYLOAD = 32;
  localparam int BUF_DEPTH = 2;
endpackage

// file: hdl/mem_cmd_if.sv
// Link between the requester and the command handler.
// Header held with req_valid; payload streams apart.
`timescale 1ns/1ps
`default_nettype none
interface mem_cmd_if;
  // Request header.
  logic req_valid;
  logic req_ready;
  logic req_unicast;
  logic [7:0] req_src_ep;
  logic [7:0] command_code_field;
  logic [7:0] command_options_field;
  logic [15:0] block_index_field;
  logic [15:0] byte_offset_field;
  logic [15:0] byte_count_field;
  // Request payload bytes.
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_data;
  // Response header and data.
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_dst_ep;
  logic [7:0] rsp_code;
  logic [7:0] response_status_field;
  logic [7:0] rsp_options;
  logic [15:0] rsp_block;
  logic [15:0] rsp_offset;
  logic [15:0] rsp_count;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  modport device (
    input req_valid, req_unicast, req_src_ep, command_code_field, command_options_field,
    input block_index_field, byte_offset_field, byte_count_field, wr_valid, wr_data,
    input rsp_ready, rd_ready,
    output req_ready, wr_ready, rsp_valid, rsp_dst_ep, rsp_code, response_status_field,
    output rsp_options, rsp_block, rsp_offset, rsp_count, rd_valid, rd_data
  );
  modport requester (
    output req_valid, req_unicast, req_src_ep, command_code_field, command_options_field,
    output block_index_field, byte_offset_field, byte_count_field, wr_valid, wr_data,
    output rsp_ready, rd_ready,
    input req_ready, wr_ready, rsp_valid, rsp_dst_ep, rsp_code, response_status_field,
    input rsp_options, rsp_block, rsp_offset, rsp_count, rd_valid, rd_data
  );
endinterface
`default_nettype wire

// file: hdl/byte_skid_buf.sv
// Two-entry byte buffer with valid and ready on both sides.
// Assumes a single clock.
`timescale 1ns/1ps
`default_nettype none
module byte_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  initial begin
    if (DEPTH != 2) $error("DEPTH must be 2");
  end
  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule // byte_skid_buf
`default_nettype wire

// file: hdl/mem_cmd_device.sv
// Command handler for the block-organised memory: write, erase-write, read, verify.
// Assumes headers held until req_ready, payload after.
// How it works
// R1: Write requests answer code 82 or 83.
// R2: Status bit zero set on failure.
// R3: Write answer echoes block, offset; count zero.
// R4: Read code 04 stays inside one block.
// R5: Requester sends zero options for read, verify.
// R6: Read request gives block, offset, count only.
// R7: Requester keeps offset plus count within block; the requester passes it unchecked and the handler flags it.
// R8: Requester keeps frame within payload limit.
// R9: Read answers code 84 with bytes read.
// R10: Answers only unicast, sent to source endpoint; a non-unicast read still streams its bytes on rd_valid.
// R11: Verify codes 05, 06 check stored image.
// R12: Valid image on install resets, boots new.
// R13: Verify requests carry zero fields, no data.
// R14: Code 03 erases whole block before writing.
// R15: Verify answer 85, option bit zero invalid.
// R16: Install answer 86 only when image invalid.
// R17: Bad range or block: no access, error.
`timescale 1ns/1ps
`default_nettype none
module mem_cmd_device #(
  parameter int BLOCK_BYTES = mem_cmd_pkg::BLOCK_BYTES,
  parameter int NUM_BLOCKS = mem_cmd_pkg::NUM_BLOCKS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Link to requester.
  mem_cmd_if.device lnk,
  // Firmware hand-off.
  output logic boot_new_image
);
  localparam int MEM_BYTES = BLOCK_BYTES * NUM_BLOCKS;
  localparam int AW = $clog2(MEM_BYTES);
  initial begin
    if (BLOCK_BYTES < 2 || BLOCK_BYTES > 32768 || NUM_BLOCKS < 1 || MEM_BYTES > 65536)
      $error("bad geometry");
  end
  typedef enum logic [2:0] {IDLE, ERASE, WRITE, READ, RESP, DRAIN, BOOT} state_e;
  state_e state_r;
  logic [7:0] mem_r [MEM_BYTES];
  logic [7:0] code_r;
  logic unicast_r;
  logic [7:0] ep_r;
  logic [15:0] blk_r;
  logic [15:0] off_r;
  logic [15:0] cnt_r;
  logic [15:0] idx_r;
  logic [7:0] status_r;
  logic [7:0] opt_r;
  logic boot_r;
  logic [7:0] rd_data_r;
  logic rd_pend_r;
  logic is_vf_r;
  // ==========================================================================
  // Request decode
  wire logic [16:0] span = {1'b0, lnk.byte_offset_field} + {1'b0, lnk.byte_count_field};
  wire logic range_bad = (lnk.block_index_field >= 16'(NUM_BLOCKS))
    || (span > 17'(BLOCK_BYTES)); // R17 R4
  wire logic is_wr = lnk.command_code_field == mem_cmd_pkg::CMD_WRITE
    || lnk.command_code_field == mem_cmd_pkg::CMD_ERASE_WRITE;
  wire logic is_rd = lnk.command_code_field == mem_cmd_pkg::CMD_READ;
  wire logic is_vf = lnk.command_code_field == mem_cmd_pkg::CMD_VERIFY
    || lnk.command_code_field == mem_cmd_pkg::CMD_VERIFY_BOOT;
  wire logic [AW-1:0] base = AW'(32'(blk_r) * BLOCK_BYTES);
  wire logic [AW-1:0] addr = AW'(32'(base) + 32'(off_r) + 32'(idx_r));
  wire logic image_ok = mem_r[0] == mem_cmd_pkg::IMAGE_MARK; // R11
  wire logic last = (idx_r + 16'd1) >= cnt_r;
  // ==========================================================================
  // Read data path through the two-entry buffer
  logic buf_in_ready;
  wire logic buf_push = (state_r == READ) && rd_pend_r;
  byte_skid_buf #(.WIDTH(8), .DEPTH(mem_cmd_pkg::BUF_DEPTH)) u_rd_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(rd_data_r),
    .out_valid(lnk.rd_valid),
    .out_ready(lnk.rd_ready),
    .out_data(lnk.rd_data)
  );
  // ==========================================================================
  // Outputs
  assign lnk.req_ready = (state_r == IDLE);
  assign lnk.wr_ready = (state_r == WRITE) || (state_r == DRAIN);
  assign lnk.rsp_valid = (state_r == RESP) && unicast_r; // R10
  assign lnk.rsp_dst_ep = ep_r; // R10
  assign lnk.rsp_code = code_r | 8'h80; // R1 R9 R15 R16
  assign lnk.response_status_field = status_r; // R2
  assign lnk.rsp_options = opt_r; // R15 R16
  assign lnk.rsp_block = is_vf_r ? 16'h0000 : blk_r; // R3 R9
  assign lnk.rsp_offset = is_vf_r ? 16'h0000 : off_r; // R3 R9
  assign lnk.rsp_count = (code_r == mem_cmd_pkg::CMD_READ && !status_r[0]) ? cnt_r : 16'h0000; // R3 R9
  assign boot_new_image = boot_r;
  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= IDLE;
      code_r <= 8'h00;
      unicast_r <= 1'b0;
      ep_r <= 8'h00;
      blk_r <= 16'h0000;
      off_r <= 16'h0000;
      cnt_r <= 16'h0000;
      idx_r <= 16'h0000;
      status_r <= mem_cmd_pkg::STATUS_OK;
      opt_r <= mem_cmd_pkg::OPT_NONE;
      boot_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_data_r <= 8'h00;
      is_vf_r <= 1'b0;
    end else begin
      case (state_r)
        IDLE: begin
          if (lnk.req_valid) begin
            code_r <= lnk.command_code_field;
            unicast_r <= lnk.req_unicast;
            ep_r <= lnk.req_src_ep;
            blk_r <= lnk.block_index_field;
            off_r <= lnk.byte_offset_field;
            cnt_r <= lnk.byte_count_field;
            idx_r <= 16'h0000;
            opt_r <= mem_cmd_pkg::OPT_NONE;
            is_vf_r <= is_vf;
            status_r <= (is_wr || is_rd) && range_bad ? mem_cmd_pkg::STATUS_FAIL
              : (is_wr || is_rd || is_vf) ? mem_cmd_pkg::STATUS_OK : mem_cmd_pkg::STATUS_FAIL; // R2 R17
            if (is_vf) begin
              opt_r <= image_ok ? mem_cmd_pkg::OPT_NONE : mem_cmd_pkg::STATUS_FAIL; // R15
              if (image_ok && lnk.command_code_field == mem_cmd_pkg::CMD_VERIFY_BOOT) begin
                state_r <= BOOT; // R12 R16
              end else begin
                state_r <= RESP;
              end
            end else if (is_wr && range_bad) begin
              state_r <= (lnk.byte_count_field != 16'h0000) ? DRAIN : RESP; // R17
            end else if (is_wr) begin
              state_r <= (lnk.command_code_field == mem_cmd_pkg::CMD_ERASE_WRITE) ? ERASE
                : (lnk.byte_count_field != 16'h0000) ? WRITE : RESP; // R14
            end else if (is_rd && !range_bad && lnk.byte_count_field != 16'h0000) begin
              state_r <= READ; // R4
            end else begin
              state_r <= RESP;
            end
          end
        end
        ERASE: begin
          mem_r[AW'(32'(base) + 32'(idx_r))] <= mem_cmd_pkg::ERASED_BYTE; // R14
          idx_r <= idx_r + 16'd1;
          if (idx_r == 16'(BLOCK_BYTES - 1)) begin
            idx_r <= 16'h0000;
            state_r <= (cnt_r != 16'h0000) ? WRITE : RESP;
          end
        end
        WRITE: begin
          if (lnk.wr_valid) begin
            mem_r[addr] <= lnk.wr_data;
            idx_r <= idx_r + 16'd1;
            if (last) state_r <= RESP;
          end
        end
        DRAIN: begin
          if (lnk.wr_valid) begin
            idx_r <= idx_r + 16'd1;
            if (last) state_r <= RESP;
          end
        end
        READ: begin
          if (!rd_pend_r) begin
            rd_data_r <= mem_r[addr]; // R9
            rd_pend_r <= 1'b1;
          end else if (buf_in_ready) begin
            rd_pend_r <= 1'b0;
            idx_r <= idx_r + 16'd1;
            if (last) state_r <= RESP;
          end
        end
        RESP: begin
          if (lnk.rsp_ready || !unicast_r) state_r <= IDLE; // R10
        end
        BOOT: begin
          boot_r <= 1'b1; // R12
        end
        default: state_r <= IDLE;
      endcase
    end
  end
endmodule // mem_cmd_device
`default_nettype wire

// file: hdl/mem_cmd_requester.sv
// Requester end: user command to link request and back.
// Assumes one answer per unicast request.
`timescale 1ns/1ps
`default_nettype none
module mem_cmd_requester #(
  parameter int MAX_PAYLOAD = mem_cmd_pkg::MAX_PAYLOAD,
  parameter int HDR_BYTES = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // User command.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_ep,
  input wire logic [15:0] cmd_block,
  input wire logic [15:0] cmd_offset,
  input wire logic [15:0] cmd_count,
  output logic cmd_reject,
  // User write bytes.
  input wire logic data_valid,
  output logic data_ready,
  input wire logic [7:0] data_in,
  // Answers to the user.
  output logic ans_valid,
  output logic [7:0] ans_code,
  output logic [7:0] ans_status,
  output logic [7:0] ans_options,
  output logic byte_valid,
  output logic [7:0] byte_data,
  // Link to handler.
  mem_cmd_if.requester lnk
);
  initial begin
    if (MAX_PAYLOAD <= HDR_BYTES) $error("payload too small");
  end
  typedef enum logic [1:0] {IDLE, HDR, DATA} state_e;
  state_e state_r;
  logic [7:0] code_r;
  logic [7:0] ep_r;
  logic [15:0] blk_r;
  logic [15:0] off_r;
  logic [15:0] cnt_r;
  logic [15:0] sent_r;
  logic ans_valid_r;
  logic [7:0] ans_code_r;
  logic [7:0] ans_status_r;
  logic [7:0] ans_opt_r;
  logic byte_valid_r;
  logic [7:0] byte_data_r;
  logic reject_r;
  // ==========================================================================
  // Request shaping
  wire logic vf = cmd_code == mem_cmd_pkg::CMD_VERIFY || cmd_code == mem_cmd_pkg::CMD_VERIFY_BOOT;
  wire logic wr = cmd_code == mem_cmd_pkg::CMD_WRITE || cmd_code == mem_cmd_pkg::CMD_ERASE_WRITE;
  wire logic too_big = wr && (32'(cmd_count) + HDR_BYTES > MAX_PAYLOAD); // R8
  assign cmd_ready = (state_r == IDLE);
  assign lnk.req_valid = (state_r == HDR);
  assign lnk.req_unicast = 1'b1;
  assign lnk.req_src_ep = ep_r;
  assign lnk.command_code_field = code_r;
  assign lnk.command_options_field = mem_cmd_pkg::OPT_NONE; // R5
  assign lnk.block_index_field = blk_r; // R6 R13
  assign lnk.byte_offset_field = off_r; // R6 R13
  assign lnk.byte_count_field = cnt_r; // R7 R13
  assign lnk.wr_valid = (state_r == DATA) && data_valid;
  assign lnk.wr_data = data_in;
  assign data_ready = (state_r == DATA) && lnk.wr_ready;
  assign lnk.rsp_ready = 1'b1;
  assign lnk.rd_ready = 1'b1;
  assign ans_valid = ans_valid_r;
  assign ans_code = ans_code_r;
  assign ans_status = ans_status_r;
  assign ans_options = ans_opt_r;
  assign byte_valid = byte_valid_r;
  assign byte_data = byte_data_r;
  assign cmd_reject = reject_r;
  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= IDLE;
      code_r <= 8'h00;
      ep_r <= 8'h00;
      blk_r <= 16'h0000;
      off_r <= 16'h0000;
      cnt_r <= 16'h0000;
      sent_r <= 16'h0000;
      reject_r <= 1'b0;
    end else begin
      reject_r <= 1'b0;
      case (state_r)
        IDLE: begin
          if (cmd_valid) begin
            if (too_big) begin
              reject_r <= 1'b1;
            end else begin
              code_r <= cmd_code;
              ep_r <= cmd_ep;
              blk_r <= vf ? 16'h0000 : cmd_block; // R13
              off_r <= vf ? 16'h0000 : cmd_offset; // R13
              cnt_r <= vf ? 16'h0000 : cmd_count; // R13
              sent_r <= 16'h0000;
              state_r <= HDR;
            end
          end
        end
        HDR: begin
          if (lnk.req_ready) begin
            state_r <= ((code_r == mem_cmd_pkg::CMD_WRITE || code_r == mem_cmd_pkg::CMD_ERASE_WRITE)
              && cnt_r != 16'h0000) ? DATA : IDLE; // R6
          end
        end
        DATA: begin
          if (lnk.wr_valid && lnk.wr_ready) begin
            sent_r <= sent_r + 16'd1;
            if (sent_r + 16'd1 == cnt_r) state_r <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ans_valid_r <= 1'b0;
      ans_code_r <= 8'h00;
      ans_status_r <= 8'h00;
      ans_opt_r <= 8'h00;
      byte_valid_r <= 1'b0;
      byte_data_r <= 8'h00;
    end else begin
      ans_valid_r <= lnk.rsp_valid;
      byte_valid_r <= lnk.rd_valid;
      if (lnk.rsp_valid) begin
        ans_code_r <= lnk.rsp_code;
        ans_status_r <= lnk.response_status_field;
        ans_opt_r <= lnk.rsp_options;
      end
      if (lnk.rd_valid) byte_data_r <= lnk.rd_data;
    end
  end
endmodule // mem_cmd_requester
`default_nettype wire

// file: bench/mem_cmd_link_assertions.sv
// Concurrent checks on the requester-handler link.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mem_cmd_link_assertions #(
  parameter int BLOCK_BYTES = 64,
  parameter int NUM_BLOCKS = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Request header.
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_unicast,
  input wire logic [7:0] req_src_ep,
  input wire logic [7:0] command_code_field,
  input wire logic [15:0] block_index_field,
  input wire logic [15:0] byte_offset_field,
  input wire logic [15:0] byte_count_field,
  // Response and read bytes.
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_dst_ep,
  input wire logic [7:0] rsp_code,
  input wire logic [7:0] response_status_field,
  input wire logic [7:0] rsp_options,
  input wire logic [15:0] rsp_block,
  input wire logic [15:0] rsp_offset,
  input wire logic [15:0] rsp_count,
  input wire logic rd_valid,
  input wire logic rd_ready
);
  // ==========================================================================
  // Request capture
  logic [7:0] code_r, ep_r;
  logic [15:0] blk_r, off_r, cnt_r, rd_cnt_r;
  logic take, bad, is_wr, is_rd;
  assign take = req_valid && req_ready;
  assign bad = (32'(blk_r) >= NUM_BLOCKS) || (32'(off_r) + 32'(cnt_r) > BLOCK_BYTES);
  assign is_wr = (code_r == mem_cmd_pkg::CMD_WRITE) || (code_r == mem_cmd_pkg::CMD_ERASE_WRITE);
  assign is_rd = code_r == mem_cmd_pkg::CMD_READ;
  always_ff @(posedge clk) begin
    if (srst) begin
      code_r <= 8'h00;
    end else if (take) begin
      code_r <= command_code_field;
    end
    if (take) begin
      ep_r <= req_src_ep;
      blk_r <= block_index_field;
      off_r <= byte_offset_field;
      cnt_r <= byte_count_field;
    end
    if (srst || take) begin
      rd_cnt_r <= 16'h0000;
    end else if (rd_valid && rd_ready) begin
      rd_cnt_r <= rd_cnt_r + 16'h0001;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence hdr_s;
    take && req_unicast && (command_code_field != mem_cmd_pkg::CMD_VERIFY_BOOT);
  endsequence
  sequence answer_s;
    ##[1:200] rsp_valid;
  endsequence
  chk_answer_bound: assert property (hdr_s |-> answer_s)
    else $error("No response.");
  chk_rsp_code: assert property (rsp_valid |-> rsp_code == (code_r | 8'h80))
    else $error("Bad code.");
  chk_status_reserved: assert property (rsp_valid |-> response_status_field[7:1] == 7'h00)
    else $error("Reserved bits.");
  chk_write_echo: assert property (rsp_valid && is_wr |-> rsp_block == blk_r
    && rsp_offset == off_r && rsp_count == 16'h0000)
    else $error("Bad write echo.");
  chk_read_echo: assert property (rsp_valid && is_rd && !bad |-> rsp_count == cnt_r
    && rsp_block == blk_r && rsp_offset == off_r && !response_status_field[0])
    else $error("Bad read echo.");
  chk_range_error: assert property (rsp_valid && (is_rd || is_wr) && bad
    |-> response_status_field[0] && rsp_count == 16'h0000)
    else $error("Range not flagged.");
  chk_read_span: assert property (rd_cnt_r <= ((is_rd && !bad) ? cnt_r : 16'h0000))
    else $error("Too many bytes.");
  chk_dst_ep: assert property (rsp_valid |-> rsp_dst_ep == ep_r)
    else $error("Wrong endpoint.");
  chk_verify_fields: assert property (rsp_valid && code_r[7:2] == 6'h01 && code_r[1:0] != 2'h0
    && code_r[1:0] != 2'h3 |-> rsp_block == 16'h0000 && rsp_offset == 16'h0000
    && rsp_count == 16'h0000)
    else $error("Verify fields set.");
  chk_install_invalid: assert property (rsp_valid && code_r == 8'h06 |-> rsp_options[0])
    else $error("Install answered.");
  chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid
    && $stable(rsp_code) && $stable(response_status_field))
    else $error("Response dropped.");
endmodule // mem_cmd_link_assertions
`default_nettype wire

// file: bench/flash_memory_remote_command_handler_tb_top.sv
// Bench: requester-handler link plus a raw-driven handler.
// Assumes all design files compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_memory_remote_command_handler_tb_top;
  // ==========================================================================
  // Signals and instances
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic data_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00, cmd_ep = 8'h00, data_in = 8'h00;
  logic [15:0] cmd_block = 16'h0000, cmd_offset = 16'h0000, cmd_count = 16'h0000;
  logic cmd_ready, cmd_reject, data_ready, ans_valid, byte_valid, boot1, boot2, seen;
  logic [7:0] ans_code, ans_status, ans_options, byte_data, a_code, a_stat, a_opt, last_dst;
  logic [7:0] rbytes[$];
  int bad_count = 0, n_compared = 0, n_ans = 0, n_rej = 0, cycles = 0;
  mem_cmd_if lnk ();
  mem_cmd_if lnk2 ();
  always #5 clk = ~clk;
  mem_cmd_device mem_cmd_device_inst (.clk(clk), .srst(srst), .lnk(lnk), .boot_new_image(boot1));
  mem_cmd_device mem_cmd_device_inst2 (.clk(clk), .srst(srst), .lnk(lnk2), .boot_new_image(boot2));
  mem_cmd_requester mem_cmd_requester_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_ep(cmd_ep), .cmd_block(cmd_block),
    .cmd_offset(cmd_offset), .cmd_count(cmd_count), .cmd_reject(cmd_reject),
    .data_valid(data_valid), .data_ready(data_ready), .data_in(data_in), .ans_valid(ans_valid),
    .ans_code(ans_code), .ans_status(ans_status), .ans_options(ans_options),
    .byte_valid(byte_valid), .byte_data(byte_data), .lnk(lnk));
  mem_cmd_link_assertions #(.BLOCK_BYTES(64), .NUM_BLOCKS(4)) chk (.clk(clk), .srst(srst),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_unicast(lnk.req_unicast),
    .req_src_ep(lnk.req_src_ep), .command_code_field(lnk.command_code_field),
    .block_index_field(lnk.block_index_field), .byte_offset_field(lnk.byte_offset_field),
    .byte_count_field(lnk.byte_count_field), .rsp_valid(lnk.rsp_valid),
    .rsp_ready(lnk.rsp_ready), .rsp_dst_ep(lnk.rsp_dst_ep), .rsp_code(lnk.rsp_code),
    .response_status_field(lnk.response_status_field), .rsp_options(lnk.rsp_options),
    .rsp_block(lnk.rsp_block), .rsp_offset(lnk.rsp_offset), .rsp_count(lnk.rsp_count),
    .rd_valid(lnk.rd_valid), .rd_ready(lnk.rd_ready));
  // ==========================================================================
  // Monitor and closing
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ans_valid === 1'b1) begin
      n_ans <= n_ans + 1;
      a_code <= ans_code;
      a_stat <= ans_status;
      a_opt <= ans_options;
    end
    if (cmd_reject === 1'b1) n_rej <= n_rej + 1;
    if (byte_valid === 1'b1) rbytes.push_back(byte_data);
    if (lnk.rsp_valid === 1'b1 && lnk.rsp_ready === 1'b1) last_dst <= lnk.rsp_dst_ep;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks made: %0d, mismatches: %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp);
    n_compared++;
    if (seen_v !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen_v);
    end
  endtask
  // ==========================================================================
  // Shared request driver
  task automatic op(input logic [7:0] code, input logic [15:0] blk, off, cnt,
    input logic [7:0] b0, input bit wait_ans);
    int n0;
    n0 = n_ans;
    rbytes.delete();
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_ep = cmd_ep + 8'h01;
    cmd_block = blk;
    cmd_offset = off;
    cmd_count = cnt;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    if (wait_ans && code[7:1] == 7'h01) begin
      for (int i = 0; i < cnt; i++) begin
        data_valid = 1'b1;
        data_in = b0 + 8'(i);
        while (data_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
      end
      data_valid = 1'b0;
    end
    if (wait_ans) begin
      wait (n_ans != n0);
      repeat (3) @(negedge clk);
      check("code", a_code, code | 8'h80);
      check("dest", last_dst, cmd_ep);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_write_read();
    logic [7:0] exp [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'hFF, 8'hFF};
    op(mem_cmd_pkg::CMD_ERASE_WRITE, 1, 0, 4, 8'h10, 1);
    check("ew status", a_stat, 0);
    op(mem_cmd_pkg::CMD_WRITE, 1, 4, 2, 8'h20, 1);
    check("write status", a_stat, 0);
    op(mem_cmd_pkg::CMD_READ, 1, 0, 8, 0, 1);
    check("rd len", 16'(rbytes.size()), 8);
    for (int i = 0; i < 8 && i < rbytes.size(); i++) check("rd byte", rbytes[i], exp[i]);
  endtask
  task automatic t_bounds();
    op(mem_cmd_pkg::CMD_ERASE_WRITE, 1, 62, 4, 8'h30, 1);
    check("ovr wr status", a_stat, 1);
    op(mem_cmd_pkg::CMD_READ, 1, 62, 2, 0, 1);
    check("edge status", a_stat, 0);
    check("edge len", 16'(rbytes.size()), 2);
    check("edge byte", rbytes[1], 8'hFF);
    op(mem_cmd_pkg::CMD_READ, 1, 60, 5, 0, 1);
    check("ovr rd status", a_stat, 1);
    check("ovr rd len", 16'(rbytes.size()), 0);
    op(mem_cmd_pkg::CMD_READ, 4, 0, 1, 0, 1);
    check("no block status", a_stat, 1);
  endtask
  task automatic t_reject();
    int n0, a0;
    n0 = n_rej;
    a0 = n_ans;
    op(mem_cmd_pkg::CMD_WRITE, 2, 0, 25, 0, 0);
    repeat (4) @(negedge clk);
    check("refused", 16'(n_rej - n0), 1);
    check("unanswered", 16'(n_ans - a0), 0);
  endtask
  task automatic raw_req(input logic uni);
    @(negedge clk);
    lnk2.req_valid = 1'b1;
    lnk2.req_unicast = uni;
    lnk2.req_src_ep = 8'h5A;
    lnk2.command_code_field = uni ? mem_cmd_pkg::CMD_VERIFY : mem_cmd_pkg::CMD_READ;
    lnk2.byte_count_field = uni ? 16'h0000 : 16'h0001;
    while (lnk2.req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    lnk2.req_valid = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (lnk2.rsp_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        check("raw dest", lnk2.rsp_dst_ep, 8'h5A);
        check("raw code", lnk2.rsp_code, mem_cmd_pkg::RSP_VERIFY);
      end
      @(negedge clk);
    end
  endtask
  task automatic t_nonuni();
    raw_req(1'b0);
    check("bcast answered", seen, 0);
    check("handler idle", lnk2.req_ready, 1);
    raw_req(1'b1);
    check("unicast answered", seen, 1);
  endtask
  task automatic reset_dut();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
  endtask
  task automatic t_verify();
    int n0;
    op(mem_cmd_pkg::CMD_ERASE_WRITE, 0, 0, 1, 8'h00, 1);
    op(mem_cmd_pkg::CMD_VERIFY, 0, 0, 0, 0, 1);
    check("vf invalid", a_opt, 1);
    op(mem_cmd_pkg::CMD_VERIFY_BOOT, 0, 0, 0, 0, 1);
    check("inst invalid", a_opt, 1);
    check("boot invalid", boot1, 0);
    op(mem_cmd_pkg::CMD_ERASE_WRITE, 0, 0, 1, mem_cmd_pkg::IMAGE_MARK, 1);
    op(mem_cmd_pkg::CMD_VERIFY, 0, 0, 0, 0, 1);
    check("vf valid", a_opt, 0);
    n0 = n_ans;
    op(mem_cmd_pkg::CMD_VERIFY_BOOT, 0, 0, 0, 0, 0);
    repeat (10) @(negedge clk);
    check("inst silent", 16'(n_ans - n0), 0);
    check("boot valid", boot1, 1);
    reset_dut();
    check("boot cleared", boot1, 0);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    lnk2.req_valid = 1'b0;
    lnk2.req_unicast = 1'b0;
    lnk2.req_src_ep = 8'h00;
    lnk2.command_code_field = 8'h00;
    lnk2.command_options_field = 8'h00;
    lnk2.block_index_field = 16'h0000;
    lnk2.byte_offset_field = 16'h0000;
    lnk2.byte_count_field = 16'h0000;
    lnk2.wr_valid = 1'b0;
    lnk2.wr_data = 8'h00;
    lnk2.rsp_ready = 1'b1;
    lnk2.rd_ready = 1'b1;
    reset_dut();
    t_write_read();
    t_bounds();
    t_reject();
    t_nonuni();
    t_verify();
    finish_test();
  end
endmodule // flash_memory_remote_command_handler_tb_top
`default_nettype wire
